// [core/xds_engine.sv]
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1 - fetch cycle first, then address and access
// R2 - stretch field in clock control bits 2-0
// R3 - move lasts stretch plus two machine cycles
// R4 - stretch resets to one, three cycles
// R5 - only external moves are lengthened
// R6 - strobe two clocks, else four per step
// R7 - wait input works only when enabled
// R8 - stretch sets minimum, waits only lengthen
// R9 - wait sampled in third clock state
// R10 - active wait adds one machine cycle
// R11 - waits unlimited, peripheral must release
// R12 - wait shares auxiliary port bit zero
// R13 - wait enable written only after unlock
// R14 - machine cycle is four clock states
// R15 - indirect form: port2 high, register low
// R16 - pointer form: selected sixteen-bit pointer
// R17 - peripheral pulls wait low, then releases
// R18 - address and strobe steady through waits
module xds_engine #(
   parameter bit HAS_AUX_PORT = 1'b1 // package exposes auxiliary port
) (
   input wire logic clock,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // core side
   input wire logic core_req,
   input wire logic core_write,
   input wire logic core_ptr_form,
   input wire logic [7:0] core_ri_low,
   input wire logic [7:0] core_wdata,
   output logic core_busy,
   output logic core_hold,
   output logic core_done,
   output logic [7:0] core_rdata,
   // external memory pins
   output logic [15:0] ext_addr,
   output logic rd_n,
   output logic wr_n,
   input wire logic [7:0] ext_data_i,
   output logic [7:0] ext_data_o,
   output logic ext_data_oe,
   input wire logic aux_port_bit0
);
   ////////////////////////////////////////////////////////////////////////
   // clock states and pin synchronisers
   logic [1:0] phase; // current clock state
   logic wait_n_s; // synchronised wait pin, low asks for time
   logic [7:0] data_s; // synchronised data bus

   xds_phase u_phase (
      .clock(clock),
      .nrst(nrst),
      .phase(phase)
   );
   xds_sync #(.W(1), .INIT(1'b1)) u_wait_sync (
      .clock(clock),
      .nrst(nrst),
      .d(aux_port_bit0),
      .q(wait_n_s)
   );
   xds_sync #(.W(8), .INIT(8'h00)) u_data_sync (
      .clock(clock),
      .nrst(nrst),
      .d(ext_data_i),
      .q(data_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [2:0] stretch_field; // access length setting
   logic wait_enable_bit; // hardware wait allowed
   logic pointer_select_bit; // picks pointer one when set
   logic [15:0] data_pointer_zero;
   logic [15:0] data_pointer_one;
   logic [7:0] port2; // high address for indirect form
   logic ta_armed; // first key seen
   logic [2:0] ta_count; // unlock window remaining
   logic waited; // last access saw a wait cycle

   // engine state
   xds_pkg::xds_state_t state;
   logic [2:0] mc; // machine cycle index inside access, saturates
   logic [2:0] s_l; // stretch latched for this move
   logic wr_l; // this move is a write
   logic strobe; // either strobe active
   logic ending; // strobe released, finish at C4

   // write decode
   wire wr_mmap = reg_wr && reg_addr == xds_pkg::OFS_MMAP;
   wire wr_ta = reg_wr && reg_addr == xds_pkg::OFS_TA;
   wire ta_open = ta_count != 3'h0;
   wire [7:0] status = {4'h0, ta_open, waited, strobe, core_busy};
   // read select, unmapped offsets read zero
   wire [7:0] rd_sel =
      reg_addr == xds_pkg::OFS_CLKCTL ? {5'h00, stretch_field} :
      reg_addr == xds_pkg::OFS_MMAP ? {wait_enable_bit, 7'h00} :
      reg_addr == xds_pkg::OFS_PSEL ? {7'h00, pointer_select_bit} :
      reg_addr == xds_pkg::OFS_DP0L ? data_pointer_zero[7:0] :
      reg_addr == xds_pkg::OFS_DP0H ? data_pointer_zero[15:8] :
      reg_addr == xds_pkg::OFS_DP1L ? data_pointer_one[7:0] :
      reg_addr == xds_pkg::OFS_DP1H ? data_pointer_one[15:8] :
      reg_addr == xds_pkg::OFS_PORT2 ? port2 :
      reg_addr == xds_pkg::OFS_STATUS ? status : 8'h00;

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clock) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_sel : 8'h00;
      end
   end

   // plain software registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         stretch_field <= xds_pkg::STRETCH_RST; // [R4]
         pointer_select_bit <= 1'b0;
         data_pointer_zero <= {xds_pkg::REG_RST, xds_pkg::REG_RST};
         data_pointer_one <= {xds_pkg::REG_RST, xds_pkg::REG_RST};
         port2 <= xds_pkg::REG_RST;
      end else if (reg_wr) begin
         unique case (reg_addr)
            xds_pkg::OFS_CLKCTL: stretch_field <=
               reg_wdata[xds_pkg::STRETCH_MSB:xds_pkg::STRETCH_LSB]; // [R2]
            xds_pkg::OFS_PSEL:
               pointer_select_bit <= reg_wdata[xds_pkg::PSEL_BIT];
            xds_pkg::OFS_DP0L: data_pointer_zero[7:0] <= reg_wdata;
            xds_pkg::OFS_DP0H: data_pointer_zero[15:8] <= reg_wdata;
            xds_pkg::OFS_DP1L: data_pointer_one[7:0] <= reg_wdata;
            xds_pkg::OFS_DP1H: data_pointer_one[15:8] <= reg_wdata;
            xds_pkg::OFS_PORT2: port2 <= reg_wdata;
            default: ;
         endcase
      end
   end

   // timed access: key1 then key2 opens a short window for the wait bit
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ta_armed <= 1'b0;
         ta_count <= 3'h0;
         wait_enable_bit <= 1'b0;
      end else begin
         ta_armed <= wr_ta && reg_wdata == xds_pkg::TA_KEY1;
         if (wr_mmap && ta_open) begin
            wait_enable_bit <= reg_wdata[xds_pkg::WAIT_EN_BIT]; // [R13]
            ta_count <= 3'h0; // one write per unlock
         end else if (wr_ta && ta_armed &&
                      reg_wdata == xds_pkg::TA_KEY2) begin
            ta_count <= xds_pkg::TA_WINDOW;
         end else if (ta_open) begin
            ta_count <= ta_count - 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // access sequencer
   // wait works only when enabled and the pin exists on this package
   wire wait_on = wait_enable_bit && HAS_AUX_PORT; // [R7] [R12]
   wire at_c3 = phase == xds_pkg::PH_C3;
   wire at_c4 = phase == xds_pkg::PH_C4;
   wire in_fetch = state == xds_pkg::XDS_FETCH;
   wire in_access = state == xds_pkg::XDS_ACCESS;
   wire final_mc = in_access && mc == s_l;
   // sample point; no upper bound on how often it extends
   wire extend = final_mc && at_c3 && wait_on && !wait_n_s; // [R9] [R11]
   // strobe opens at C2 for stretch zero, else at C4 of first cycle
   wire [1:0] open_ph = (s_l == 3'h0) ? xds_pkg::PH_C1 : xds_pkg::PH_C3;
   wire strobe_on = in_access && mc == 3'h0 && phase == open_ph; // [R6]
   wire strobe_off = final_mc && at_c3 && !extend; // [R8] [R10]
   // address source: pointer form or port2 plus working register
   wire [15:0] ptr = pointer_select_bit ? data_pointer_one :
                     data_pointer_zero; // [R16]
   wire [15:0] ind = {port2, core_ri_low}; // [R15]
   wire [15:0] next_addr = core_ptr_form ? ptr : ind;
   wire load_addr = in_fetch && at_c4; // [R1]
   wire finish = in_access && at_c4 && ending;

   // state register; a request is taken at C4, fetch runs C1 to C4
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state <= xds_pkg::XDS_IDLE;
      end else begin
         unique case (state)
            xds_pkg::XDS_IDLE: if (core_req && at_c4) begin
               state <= xds_pkg::XDS_FETCH; // [R1] [R5]
            end
            xds_pkg::XDS_FETCH: if (at_c4) begin
               state <= xds_pkg::XDS_ACCESS; // [R14]
            end
            xds_pkg::XDS_ACCESS: if (finish) begin
               state <= xds_pkg::XDS_IDLE; // [R3]
            end
         endcase
      end
   end

   // per move latches; stretch is frozen so software cannot skew a move
   always_ff @(posedge clock) begin
      if (!nrst) begin
         s_l <= xds_pkg::STRETCH_RST;
         wr_l <= 1'b0;
         ext_data_o <= 8'h00;
      end else if (state == xds_pkg::XDS_IDLE && core_req && at_c4) begin
         s_l <= stretch_field;
         wr_l <= core_write;
         ext_data_o <= core_wdata;
      end
   end

   // machine cycle index, held at the final value during waits
   always_ff @(posedge clock) begin
      if (!nrst) begin
         mc <= 3'h0;
      end else if (load_addr || finish) begin
         mc <= 3'h0;
      end else if (in_access && at_c4 && mc != s_l) begin
         mc <= mc + 3'h1;
      end
   end

   // strobe and ending flag
   always_ff @(posedge clock) begin
      if (!nrst) begin
         strobe <= 1'b0;
         ending <= 1'b0;
      end else begin
         strobe <= strobe_on || (strobe && !strobe_off); // [R18]
         ending <= strobe_off || (ending && !finish);
      end
   end

   // wait history for the status register
   always_ff @(posedge clock) begin
      if (!nrst) begin
         waited <= 1'b0;
      end else if (load_addr) begin
         waited <= 1'b0;
      end else if (extend) begin
         waited <= 1'b1;
      end
   end

   // pins and core handshake, all registered
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ext_addr <= 16'h0000;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         ext_data_oe <= 1'b0;
         core_busy <= 1'b0;
         core_hold <= 1'b0;
         core_done <= 1'b0;
         core_rdata <= 8'h00;
      end else begin
         if (load_addr) begin
            ext_addr <= next_addr; // [R1] [R18]
         end
         rd_n <= !(!wr_l && (strobe_on || (strobe && !strobe_off)));
         wr_n <= !(wr_l && (strobe_on || (strobe && !strobe_off)));
         ext_data_oe <= wr_l && (load_addr || (in_access && !finish));
         core_busy <= (state == xds_pkg::XDS_IDLE) ? core_req && at_c4
                      : !finish;
         // core frozen beyond the normal second machine cycle; at stretch zero only in C1 of each added cycle
         core_hold <= in_access && !finish &&
                      (at_c4 || mc != 3'h0); // [R5]
         core_done <= finish;
         // data path lags two clocks, so take it as the move ends
         if (finish && !wr_l) begin
            core_rdata <= data_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [6:0] move_clk; // clocks since fetch began
   logic [4:0] strobe_clk; // clocks of current strobe
   always_ff @(posedge clock) begin
      if (!nrst) begin
         move_clk <= 7'h00;
         strobe_clk <= 5'h00;
      end else begin
         move_clk <= (state == xds_pkg::XDS_IDLE) ? 7'h00 : move_clk + 7'h1;
         strobe_clk <= strobe ? strobe_clk + 5'h01 : 5'h00;
      end
   end

   a_fetch_len: assert property (@(posedge clock) disable iff (!nrst) // [R1]
      $rose(in_fetch) |-> in_fetch [*4] ##1 in_access)
      else $error("fetch cycle not four clocks");
   a_stretch_reset: assert property (@(posedge clock) // [R4]
      disable iff (!nrst) $rose(nrst) |->
      stretch_field == xds_pkg::STRETCH_RST)
      else $error("stretch not one after reset");
   a_move_len: assert property (@(posedge clock) disable iff (!nrst) // [R3]
      finish && !waited |-> move_clk + 7'h1 == xds_pkg::xds_total_clk(s_l))
      else $error("move length wrong");
   a_move_min: assert property (@(posedge clock) disable iff (!nrst) // [R8]
      finish |-> move_clk + 7'h1 >= xds_pkg::xds_total_clk(s_l))
      else $error("move shorter than stretch");
   a_strobe_width: assert property (@(posedge clock) // [R6]
      disable iff (!nrst) $fell(strobe) && !waited |->
      $past(strobe_clk) + 5'h01 == xds_pkg::xds_strobe_clk(s_l))
      else $error("strobe width wrong");
   a_nowait_end: assert property (@(posedge clock) disable iff (!nrst) // [R7]
      final_mc && at_c3 && !wait_on |=> !strobe ##1 !in_access)
      else $error("access not ended without wait");
   a_wait_extend: assert property (@(posedge clock) disable iff (!nrst) // [R10]
      extend |=> strobe [*4])
      else $error("wait did not add a cycle");
   a_wait_lock: assert property (@(posedge clock) disable iff (!nrst) // [R13]
      $changed(wait_enable_bit) |-> $past(ta_open && wr_mmap))
      else $error("wait enable changed while locked");
   a_addr_stable: assert property (@(posedge clock) disable iff (!nrst) // [R18]
      strobe && $past(strobe) |-> $stable(ext_addr))
      else $error("address moved under strobe");
   a_hold_only: assert property (@(posedge clock) disable iff (!nrst) // [R5]
      core_hold |-> $past(in_access))
      else $error("hold outside external move");
   a_phase_order: assert property (@(posedge clock) disable iff (!nrst) // [R14]
      at_c4 |=> phase == xds_pkg::PH_C1)
      else $error("clock state order broken");
endmodule

// [core/xds_phase.sv]
`timescale 1ns/1ps
// free running clock state counter, C1 to C4
module xds_phase (
   input wire logic clock,
   input wire logic nrst,
   output logic [1:0] phase
);
   // wraps naturally after C4 back to C1
   always_ff @(posedge clock) begin
      if (!nrst) begin
         phase <= xds_pkg::PH_C1;
      end else begin
         phase <= phase + 2'h1;
      end
   end
endmodule

// [core/xds_sync.sv]
`timescale 1ns/1ps
// two flop synchroniser for pin inputs
module xds_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta; // first stage, read only by q

   always_ff @(posedge clock) begin
      if (!nrst) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// [pkg/xds_pkg.sv]
package xds_pkg;
   // register offsets on the plain register port
   localparam logic [7:0] OFS_CLKCTL = 8'h00; // clock_control_reg
   localparam logic [7:0] OFS_MMAP = 8'h01;   // memory_map_reg
   localparam logic [7:0] OFS_TA = 8'h02;     // timed access key register
   localparam logic [7:0] OFS_PSEL = 8'h03;   // pointer select
   localparam logic [7:0] OFS_DP0L = 8'h04;   // data_pointer_zero low
   localparam logic [7:0] OFS_DP0H = 8'h05;   // data_pointer_zero high
   localparam logic [7:0] OFS_DP1L = 8'h06;   // data_pointer_one low
   localparam logic [7:0] OFS_DP1H = 8'h07;   // data_pointer_one high
   localparam logic [7:0] OFS_PORT2 = 8'h08;  // port 2 register, high address
   localparam logic [7:0] OFS_STATUS = 8'h09; // access engine status
   // field positions and reset values
   localparam int STRETCH_MSB = 2;
   localparam int STRETCH_LSB = 0;
   localparam logic [2:0] STRETCH_RST = 3'h1;
   localparam int WAIT_EN_BIT = 7;
   localparam int PSEL_BIT = 0;
   localparam logic [7:0] REG_RST = 8'h00;
   // status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_STROBE = 1;
   localparam int ST_WAITED = 2;
   localparam int ST_TA_OPEN = 3;
   // timed access unlock keys and window
   localparam logic [7:0] TA_KEY1 = 8'hAA;
   localparam logic [7:0] TA_KEY2 = 8'h55;
   localparam logic [2:0] TA_WINDOW = 3'h4;
   // clock states of a machine cycle
   localparam logic [1:0] PH_C1 = 2'h0;
   localparam logic [1:0] PH_C2 = 2'h1;
   localparam logic [1:0] PH_C3 = 2'h2;
   localparam logic [1:0] PH_C4 = 2'h3;
   // timing figures in clocks and machine cycles
   localparam logic [4:0] STROBE_S0_CLK = 5'h02;
   localparam logic [4:0] CLK_PER_STEP = 5'h04;
   localparam logic [6:0] CLK_PER_MC = 7'h04;
   localparam logic [6:0] MIN_MC = 7'h02;

   typedef enum logic [1:0] {XDS_IDLE, XDS_FETCH, XDS_ACCESS} xds_state_t;

   // strobe width in clocks for a stretch value
   function automatic logic [4:0] xds_strobe_clk(input logic [2:0] s);
      return (s == 3'h0) ? STROBE_S0_CLK : 5'(s) * CLK_PER_STEP;
   endfunction

   // whole move length in clocks, opcode fetch included
   function automatic logic [6:0] xds_total_clk(input logic [2:0] s);
      return (7'(s) + MIN_MC) * CLK_PER_MC;
   endfunction
endpackage

// [tb/tb_top.sv]
`timescale 1ns/1ps
// bench for the external data move engine
module tb_top;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic core_req = 1'b0;
   logic core_write = 1'b0;
   logic core_ptr_form = 1'b0;
   logic [7:0] core_ri_low = 8'h00;
   logic [7:0] core_wdata = 8'h00;
   logic core_busy, core_hold, core_done;
   logic [7:0] core_rdata, ext_data_i, ext_data_o;
   logic [15:0] ext_addr;
   logic rd_n, wr_n, ext_data_oe, aux_port_bit0;
   logic [7:0] wait_clks = 8'h00; // slow-device setting of the memory model
   int err_total = 0;
   int n_checks = 0;
   logic [7:0] shadow [256]; // expected memory contents
   logic [15:0] a;

   ////////////////////////////////////////////////////////////////////////
   xds_engine #(.HAS_AUX_PORT(1'b1)) u_dut (
      .clock(clock), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .core_req(core_req),
      .core_write(core_write), .core_ptr_form(core_ptr_form),
      .core_ri_low(core_ri_low), .core_wdata(core_wdata),
      .core_busy(core_busy), .core_hold(core_hold),
      .core_done(core_done), .core_rdata(core_rdata),
      .ext_addr(ext_addr), .rd_n(rd_n), .wr_n(wr_n),
      .ext_data_i(ext_data_i), .ext_data_o(ext_data_o),
      .ext_data_oe(ext_data_oe), .aux_port_bit0(aux_port_bit0));

   xds_mem_model u_mem (
      .clock(clock), .ext_addr(ext_addr), .rd_n(rd_n), .wr_n(wr_n),
      .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
      .ext_data_i(ext_data_i), .wait_n(aux_port_bit0),
      .wait_clks(wait_clks));

   // 100 MHz clock
   initial begin
      forever #5 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one write cycle; strobe stays high until rreg or move lowers it
   task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rreg(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, exp}, "reg read");
   endtask

   // one move; counts length, strobe and hold cycles from taking
   task automatic move(input logic wr, ptr, input logic [7:0] ri,
                       input logic [15:0] ad, input logic [7:0] d,
                       input int s, w);
      int n, sw, hc, bad;
      logic [7:0] ex;
      n = 0;
      sw = 0;
      hc = 0;
      bad = 0;
      ex = shadow[ad[7:0]];
      @(posedge clock);
      reg_wr <= 1'b0;
      core_write <= wr;
      core_ptr_form <= ptr;
      core_ri_low <= ri;
      core_wdata <= d;
      core_req <= 1'b1;
      // request waits for the machine cycle boundary
      while (core_busy !== 1'b1 && n < 8) begin
         @(posedge clock);
         #1 n++;
      end
      n = 0;
      while (core_done !== 1'b1 && n < 400) begin
         @(posedge clock);
         #1 n++;
         if (n == 4) chk(ext_addr, ad, "address");
         if (rd_n === 1'b0 || wr_n === 1'b0) begin
            sw++;
            if (ext_addr !== ad) bad++;
         end
         if (core_hold === 1'b1) hc++;
      end
      chk(16'(n), 16'(4 * (s + 2 + w)), "length");
      chk(16'(sw), 16'((s == 0) ? 2 : 4 * (s + w)), "strobe");
      chk(16'(hc), 16'(4 * (s + w)), "hold");
      chk(16'(bad), 16'h0000, "address held");
      if (!wr) begin
         chk({8'h00, core_rdata}, {8'h00, ex}, "read data");
      end else begin
         shadow[ad[7:0]] = d;
      end
      // done lands in C1, so dropping here avoids a second take
      @(posedge clock);
      core_req <= 1'b0;
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog, well beyond the several hundred cycles the tests need
   initial begin
      #200000;
      err_total++;
      report_and_stop;
   end

   // main sequence
   initial begin
      for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'h5A;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      rreg(xds_pkg::OFS_CLKCTL, 8'h01);
      rreg(xds_pkg::OFS_MMAP, 8'h00);
      rreg(8'hFF, 8'h00); // unmapped place reads zero
      rreg(xds_pkg::OFS_TA, 8'h00); // key register is write only
      wreg(xds_pkg::OFS_DP0H, 8'h12);
      wreg(xds_pkg::OFS_DP1H, 8'h34);
      wreg(xds_pkg::OFS_PORT2, 8'h56);
      wreg(xds_pkg::OFS_DP0L, 8'h20);
      // stretch straight out of reset
      move(1'b0, 1'b1, 8'h00, 16'h1220, 8'h00, 1, 0);
      // every stretch value, both forms, both pointers, mixed write and read pass then reads
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 8; k++) begin
            wreg(xds_pkg::OFS_CLKCTL, {5'h00, 3'(k)});
            rreg(xds_pkg::OFS_CLKCTL, {5'h00, 3'(k)});
            wreg(xds_pkg::OFS_DP0L, 8'h30 + 8'(k));
            wreg(xds_pkg::OFS_DP1L, 8'h40 + 8'(k));
            wreg(xds_pkg::OFS_PSEL, {7'h00, k[0]});
            if (k[1]) a = k[0] ? {8'h34, 8'h40 + 8'(k)}
                                : {8'h12, 8'h30 + 8'(k)};
            else a = {8'h56, 8'h60 + 8'(k)};
            move((p == 0) ? (k[0] ^ k[2]) : 1'b0, k[1], 8'h60 + 8'(k), a,
                 8'hC0 + 8'(k), k, 0);
         end
      end
      // wait pin held low but waiting not enabled
      wait_clks <= 8'h08;
      wreg(xds_pkg::OFS_CLKCTL, 8'h01);
      move(1'b0, 1'b0, 8'h70, 16'h5670, 8'h00, 1, 0);
      // enable refused without the unlock keys
      wreg(xds_pkg::OFS_MMAP, 8'h80);
      rreg(xds_pkg::OFS_MMAP, 8'h00);
      wreg(xds_pkg::OFS_TA, xds_pkg::TA_KEY1);
      wreg(xds_pkg::OFS_TA, xds_pkg::TA_KEY2);
      wreg(xds_pkg::OFS_MMAP, 8'h80);
      rreg(xds_pkg::OFS_MMAP, 8'h80);
      // slow device adds two cycles at stretch one
      move(1'b0, 1'b0, 8'h70, 16'h5670, 8'h00, 1, 2);
      rreg(xds_pkg::OFS_STATUS, 8'h04);
      // one added cycle on a write at stretch two
      wreg(xds_pkg::OFS_CLKCTL, 8'h02);
      move(1'b1, 1'b0, 8'h71, 16'h5671, 8'hA5, 2, 1);
      // pin released: stretch alone sets the length
      wait_clks <= 8'h00;
      wreg(xds_pkg::OFS_CLKCTL, 8'h03);
      move(1'b0, 1'b0, 8'h71, 16'h5671, 8'h00, 3, 0);
      report_and_stop;
   end
endmodule

// [tb/xds_mem_model.sv]
`timescale 1ns/1ps
// external data memory with an optional slow-device wait pin
module xds_mem_model (
   input wire logic clock,
   input wire logic [15:0] ext_addr,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] ext_data_o,
   input wire logic ext_data_oe,
   output logic [7:0] ext_data_i,
   output logic wait_n,
   input wire logic [7:0] wait_clks
);
   logic [7:0] mem [256]; // only the low address byte decodes
   logic [7:0] last_rd; // last value put on the bus
   int cnt; // clocks the strobe has been low so far
   wire rd_act = (rd_n == 1'b0); // read strobe active
   wire strobe_act = (rd_n == 1'b0) || (wr_n == 1'b0);

   ////////////////////////////////////////////////////////////////////////
   // contents start as a known pattern the bench can predict
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end

   // released bus shows the inverse, so a stale sample never matches
   assign ext_data_i = rd_act ? mem[ext_addr[7:0]] : ~last_rd;

   // pin pulled low until the strobe has run wait_clks clocks
   // pull-up level once released, so the access can finish
   assign wait_n = !((wait_clks != 8'h00) && (cnt < int'(wait_clks)));

   ////////////////////////////////////////////////////////////////////////
   // strobe counter, write capture and bus memory
   // plain always: the contents are also preset by the initial block
   always @(posedge clock) begin
      if (strobe_act) begin
         cnt <= cnt + 1;
      end else begin
         cnt <= 0;
      end
      if (rd_act) begin
         last_rd <= ext_data_i;
      end
      if ((wr_n == 1'b0) && ext_data_oe) begin
         mem[ext_addr[7:0]] <= ext_data_o;
      end
   end
endmodule
